// *** hdl/icss_top.sv ***
// Internal clock source select: oscillator enables, trim, postscaler and system clock mux
//
// How it works
// (RL1) Multiplier on if config or software enable set; config bit overrides software.
// (RL2) System clock select 01 picks the 32.768 kHz Timer1 crystal tick.
// (RL3) RC and internal modes: clock-out enable makes output pin clock or GPIO.
// (RL4) Internal oscillator mode releases the input pin for GPIO.
// (RL5) High oscillator on for high codes, once medium runs, when select 00 with internal config, or select 1x.
// (RL6) Medium oscillator on for every non-low code when select 00 with internal config, or select 1x.
// (RL7) Low oscillator on for code 000x internally, or for power-up, watchdog, monitor.
// (RL8) 16 MHz high clock is 32 times the 500 kHz medium step.
// (RL9) Locked flag after lock time, stable flag after longer settle time.
// (RL10) High ready flag set while the high oscillator runs.
// (RL11) Medium and low ready flags set while those oscillators run.
// (RL12) Trim is 6-bit two's complement, resets zero; 1Fh max, 20h min.
// (RL13) Trim scales the medium step, so medium and high shift together.
// (RL14) Applied trim walks one step per slew time; no done flag.
// (RL15) Trim never touches the low oscillator step.
// (RL16) Low oscillator tick feeds power-up timer, watchdog and fail-safe monitor.
// (RL17) Select field covers 32 MHz down to 31.25 kHz plus 31 kHz low.
// (RL18) Reset loads frequency select with 0111, which is 500 kHz.
// (RL19) Codes 0010/0011, 0101/1000 and 0110/1001 reach one frequency from different sources.
// (RL20) Medium-derived frequencies come through one postscaler and mux.
// (RL21) System tick waits until the new oscillator reports ready.
// (RL22) Select 00 config source, 01 Timer1, 1x internal; clears on reset.
// (RL23) 32 MHz only with multiplier, code 111x, select 00, internal config.
// (RL24) Without multiplier the selected source passes straight through.
`timescale 1ns/1ps
`include "icss_regs.svh"
module icss_top
    import icss_pkg::*;
(
    input  wire logic            clock_in,
    input  wire logic            rst_b_in,
    input  wire logic            clk_en_in,
    input  wire logic [2:0]      cfg_source_select_in,
    input  wire logic            cfg_multiplier_enable_in,
    input  wire logic            cfg_clock_out_enable_in,
    input  wire logic            ctrl_wr_in,
    input  wire icss_ctrl_type   ctrl_in,
    input  wire logic            trim_wr_in,
    input  wire logic [5:0]      trim_in,
    input  wire logic            powerup_timer_need_in,
    input  wire logic            watchdog_need_in,
    input  wire logic            failsafe_need_in,
    input  wire logic            ext_clk_tick_in,
    input  wire logic            timer1_tick_in,
    input  wire logic            timer1_ready_in,
    output icss_ctrl_type        osc_control_reg_out,
    output icss_status_type      osc_status_reg_out,
    output logic [5:0]           osc_trim_reg_out,
    output logic [2:0]           osc_enable_out,
    output logic                 multiplier_on_out,
    output logic                 sys_tick_out,
    output logic                 low_freq_tick_out,
    output logic                 osc_input_pin_gpio_out,
    output logic                 osc_output_pin_gpio_out,
    output logic                 osc_output_pin_out,
    output logic                 osc_output_pin_oe_out
);

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_b_q;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_q <= 1'b0;
            rst_b_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_b_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Frequency select decode
    // ------------------------------------------------------------------
    function automatic icss_freq_type freq_decode(input logic [3:0] ifs);
        icss_freq_type f;
        f.src   = SRC_HF;
        f.shift = 4'h0;
        case (ifs)                                                    // RL17
            4'h0, 4'h1: begin f.src = SRC_LF; f.shift = 4'h0; end
            4'h2:       begin f.src = SRC_MF; f.shift = 4'h4; end     // RL19
            4'h3:       begin f.src = SRC_HF; f.shift = 4'h9; end     // RL19
            4'h4:       begin f.src = SRC_HF; f.shift = 4'h8; end
            4'h5:       begin f.src = SRC_HF; f.shift = 4'h7; end
            4'h6:       begin f.src = SRC_HF; f.shift = 4'h6; end
            4'h7:       begin f.src = SRC_MF; f.shift = 4'h0; end
            4'h8:       begin f.src = SRC_MF; f.shift = 4'h2; end
            4'h9:       begin f.src = SRC_MF; f.shift = 4'h1; end
            4'ha:       begin f.src = SRC_MF; f.shift = 4'h0; end
            4'hb:       begin f.src = SRC_HF; f.shift = 4'h4; end
            4'hc:       begin f.src = SRC_HF; f.shift = 4'h3; end
            4'hd:       begin f.src = SRC_HF; f.shift = 4'h2; end
            4'he:       begin f.src = SRC_HF; f.shift = 4'h1; end
            default:    begin f.src = SRC_HF; f.shift = 4'h0; end
        endcase
        return f;
    endfunction

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    icss_ctrl_type ctrl_q;
    logic [5:0]    trim_q;

    always_ff @(posedge clock_in or negedge rst_b_q) begin
        if (!rst_b_q) begin
            ctrl_q.sw_multiplier_enable <= 1'b0;
            ctrl_q.int_freq_select      <= `ICSS_IFS_RESET;           // RL18
            ctrl_q.sys_clk_select       <= `ICSS_SCS_RESET;           // RL22
        end else if (clk_en_in && ctrl_wr_in) begin
            ctrl_q <= ctrl_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_q) begin
        if (!rst_b_q) begin
            trim_q <= `ICSS_TRIM_RESET;                               // RL12
        end else if (clk_en_in && trim_wr_in) begin
            trim_q <= trim_in;
        end
    end

    assign osc_control_reg_out = ctrl_q;
    assign osc_trim_reg_out    = trim_q;

    // ------------------------------------------------------------------
    // Gradual trim: the oscillator drifts, it does not jump
    // ------------------------------------------------------------------
    logic [5:0]  trim_now_q;
    logic [11:0] slew_cnt_q;
    logic        slew_due;

    assign slew_due = (slew_cnt_q == 12'(`ICSS_TRIM_SLEW_CYC - 1));

    always_ff @(posedge clock_in or negedge rst_b_q) begin
        if (!rst_b_q) begin
            trim_now_q <= `ICSS_TRIM_RESET;
            slew_cnt_q <= '0;
        end else if (clk_en_in) begin
            slew_cnt_q <= slew_due ? 12'h000 : slew_cnt_q + 12'h001;
            if (slew_due && trim_now_q != trim_q) begin
                if ($signed(trim_now_q) < $signed(trim_q)) begin      // RL14
                    trim_now_q <= trim_now_q + 6'h01;
                end else begin
                    trim_now_q <= trim_now_q - 6'h01;
                end
            end
        end
    end

    logic [31:0] mf_step;
    logic [31:0] trim_ofs;

    assign trim_ofs = 32'($signed(trim_now_q) * $signed(`ICSS_TRIM_UNIT));
    assign mf_step  = `ICSS_MF_STEP + trim_ofs;                       // RL13

    // ------------------------------------------------------------------
    // Oscillator enables
    // ------------------------------------------------------------------
    icss_freq_type fsel;
    logic          cfg_int;
    logic          int_sel;
    logic          lf_need;
    logic [2:0]    osc_en;
    logic [2:0]    osc_run;

    assign fsel    = freq_decode(ctrl_q.int_freq_select);
    assign cfg_int = (cfg_source_select_in == `ICSS_CFG_INTERNAL);
    assign int_sel = ctrl_q.sys_clk_select[1] ||
                     (ctrl_q.sys_clk_select == `ICSS_SCS_CONFIG && cfg_int);
    assign lf_need = powerup_timer_need_in || watchdog_need_in || failsafe_need_in;

    assign osc_en[SRC_LF] = (int_sel && fsel.src == SRC_LF) || lf_need;      // RL7
    assign osc_en[SRC_MF] = int_sel && fsel.src != SRC_LF;                    // RL6
    // High clock is built on the medium one, so it waits for it
    assign osc_en[SRC_HF] = int_sel && fsel.src == SRC_HF && osc_run[SRC_MF]; // RL5 RL8
    assign osc_enable_out = osc_en;

    // ------------------------------------------------------------------
    // Oscillator warm-up, one per source
    // ------------------------------------------------------------------
    localparam logic [11:0] WARM_CYC [3] = '{
        12'(`ICSS_LF_WARM_CYC),
        12'(`ICSS_MF_WARM_CYC),
        12'(`ICSS_HF_WARM_CYC)
    };

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_osc
            icss_osc_state_type st_q;
            logic [11:0]        cnt_q;

            always_ff @(posedge clock_in or negedge rst_b_q) begin
                if (!rst_b_q) begin
                    st_q  <= OSC_OFF;
                    cnt_q <= '0;
                end else if (clk_en_in) begin
                    case (st_q)
                        OSC_OFF: begin
                            cnt_q <= '0;
                            if (osc_en[g]) begin
                                st_q <= OSC_WARM;
                            end
                        end
                        OSC_WARM: begin
                            cnt_q <= cnt_q + 12'h001;
                            if (!osc_en[g]) begin
                                st_q <= OSC_OFF;
                            end else if (cnt_q == WARM_CYC[g] - 12'h001) begin
                                st_q <= OSC_RUN;
                            end
                        end
                        OSC_RUN: begin
                            if (!osc_en[g]) begin
                                st_q <= OSC_OFF;
                            end
                        end
                        default: begin
                            st_q <= OSC_OFF;
                        end
                    endcase
                end
            end

            assign osc_run[g] = (st_q == OSC_RUN);
        end
    endgenerate

    // ------------------------------------------------------------------
    // High oscillator lock and settle
    // ------------------------------------------------------------------
    logic [11:0] lock_cnt_q;

    always_ff @(posedge clock_in or negedge rst_b_q) begin
        if (!rst_b_q) begin
            lock_cnt_q <= '0;
        end else if (clk_en_in) begin
            if (!osc_run[SRC_HF]) begin
                lock_cnt_q <= '0;
            end else if (lock_cnt_q != 12'(`ICSS_HF_STABLE_CYC)) begin
                lock_cnt_q <= lock_cnt_q + 12'h001;
            end
        end
    end

    assign osc_status_reg_out.high_freq_ready_flag  = osc_run[SRC_HF];       // RL10
    assign osc_status_reg_out.high_freq_locked_flag =
        osc_run[SRC_HF] && lock_cnt_q >= 12'(`ICSS_HF_LOCK_CYC);             // RL9
    assign osc_status_reg_out.high_freq_stable_flag =
        osc_run[SRC_HF] && lock_cnt_q == 12'(`ICSS_HF_STABLE_CYC);           // RL9
    assign osc_status_reg_out.mid_freq_ready_flag   = osc_run[SRC_MF];       // RL11
    assign osc_status_reg_out.low_freq_ready_flag   = osc_run[SRC_LF];       // RL11

    // ------------------------------------------------------------------
    // Oscillator tick streams
    // ------------------------------------------------------------------
    logic [2:0] src_tick;
    logic       pll_tick;
    logic       pll_int;
    logic       mult_on;

    assign mult_on = cfg_multiplier_enable_in || ctrl_q.sw_multiplier_enable; // RL1
    assign multiplier_on_out = mult_on;
    assign pll_int = mult_on && cfg_int &&
                     ctrl_q.sys_clk_select == `ICSS_SCS_CONFIG &&
                     ctrl_q.int_freq_select[3:1] == `ICSS_IFS_PLL_TOP;        // RL23

    icss_nco #(.WIDTH(32)) u_lf (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_q),
        .clk_en_in (clk_en_in),
        .run_in    (osc_run[SRC_LF]),
        .step_in   (`ICSS_LF_STEP),                                   // RL15
        .tick_out  (src_tick[SRC_LF])
    );

    icss_nco #(.WIDTH(32)) u_mf (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_q),
        .clk_en_in (clk_en_in),
        .run_in    (osc_run[SRC_MF]),
        .step_in   (mf_step),
        .tick_out  (src_tick[SRC_MF])
    );

    icss_nco #(.WIDTH(32)) u_hf (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_q),
        .clk_en_in (clk_en_in),
        .run_in    (osc_run[SRC_HF]),
        .step_in   (mf_step << `ICSS_HF_SHIFT),                       // RL8
        .tick_out  (src_tick[SRC_HF])
    );

    // The multiplier stage runs at 64 times the medium step: 32 MHz for code 1110 or 1111
    icss_nco #(.WIDTH(32)) u_pll (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_q),
        .clk_en_in (clk_en_in),
        .run_in    (pll_int && osc_run[SRC_HF]),
        .step_in   (mf_step << `ICSS_PLL_SHIFT),                      // RL23
        .tick_out  (pll_tick)
    );

    assign low_freq_tick_out = src_tick[SRC_LF];                      // RL16

    // ------------------------------------------------------------------
    // Postscaler and internal mux
    // ------------------------------------------------------------------
    logic [8:0] post_cnt_q;
    logic [8:0] post_mask;
    logic       src_ready;
    logic       src_pulse;
    logic       int_tick;

    assign post_mask = 9'((10'h001 << fsel.shift) - 10'h001);
    assign src_ready = osc_run[fsel.src];
    assign src_pulse = src_tick[fsel.src] && src_ready;

    always_ff @(posedge clock_in or negedge rst_b_q) begin
        if (!rst_b_q) begin
            post_cnt_q <= '0;
        end else if (clk_en_in && src_pulse) begin
            post_cnt_q <= post_cnt_q + 9'h001;                        // RL20
        end
    end

    // Same-source changes only move the mask, so they take effect at once
    assign int_tick = src_pulse && ((post_cnt_q & post_mask) == post_mask); // RL19 RL21

    // ------------------------------------------------------------------
    // System clock select
    // ------------------------------------------------------------------
    logic sys_tick_d;
    logic sys_tick_q;

    always_comb begin
        case (ctrl_q.sys_clk_select)
            `ICSS_SCS_CONFIG: begin                                   // RL22
                if (cfg_int) begin
                    sys_tick_d = pll_int ? pll_tick : int_tick;       // RL24
                end else begin
                    // External multiplier path is outside this model: pass through
                    sys_tick_d = ext_clk_tick_in;                     // RL24
                end
            end
            `ICSS_SCS_TIMER1: begin
                sys_tick_d = timer1_tick_in && timer1_ready_in;       // RL2
            end
            default: begin
                sys_tick_d = int_tick;                                // RL22
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_b_q) begin
        if (!rst_b_q) begin
            sys_tick_q <= 1'b0;
        end else if (clk_en_in) begin
            sys_tick_q <= sys_tick_d;
        end
    end

    assign sys_tick_out = sys_tick_q;

    // ------------------------------------------------------------------
    // Pin reuse
    // ------------------------------------------------------------------
    logic clkout_q;
    logic out_pin_free;

    always_ff @(posedge clock_in or negedge rst_b_q) begin
        if (!rst_b_q) begin
            clkout_q <= 1'b0;
        end else if (clk_en_in && sys_tick_q) begin
            clkout_q <= ~clkout_q;
        end
    end

    // Crystal modes keep both pins for the resonator
    assign out_pin_free = cfg_source_select_in == `ICSS_CFG_RC ||
                          cfg_source_select_in >= `ICSS_CFG_INTERNAL;

    assign osc_input_pin_gpio_out  = cfg_int;                                    // RL4
    assign osc_output_pin_oe_out   = out_pin_free && cfg_clock_out_enable_in;    // RL3
    assign osc_output_pin_gpio_out = out_pin_free && !cfg_clock_out_enable_in;   // RL3
    assign osc_output_pin_out      = osc_output_pin_oe_out && clkout_q;

endmodule

// *** hdl/icss_regs.svh ***
// Field values, model steps and timing counts for the internal clock source select block
`ifndef ICSS_REGS_SVH
`define ICSS_REGS_SVH

// ----------------------------------------------------------------------
// Source codes
// ----------------------------------------------------------------------
`define ICSS_CFG_RC           3'h3
`define ICSS_CFG_INTERNAL     3'h4
`define ICSS_SCS_CONFIG       2'h0
`define ICSS_SCS_TIMER1       2'h1

// ----------------------------------------------------------------------
// Reset values and multiplier top code
// ----------------------------------------------------------------------
`define ICSS_IFS_RESET        4'h7
`define ICSS_SCS_RESET        2'h0
`define ICSS_TRIM_RESET       6'h00
`define ICSS_IFS_PLL_TOP      3'h7

// ----------------------------------------------------------------------
// Oscillator model steps (32-bit phase per 10 ns clock)
// ----------------------------------------------------------------------
`define ICSS_MF_STEP          32'h0147ae14
`define ICSS_LF_STEP          32'h001450f0
`define ICSS_TRIM_UNIT        32'h000029f1
`define ICSS_HF_SHIFT         5
`define ICSS_PLL_SHIFT        6

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ICSS_CLK_PERIOD_NS    10
`define ICSS_LF_WARM_NS       2000
`define ICSS_MF_WARM_NS       1000
`define ICSS_HF_WARM_NS       500
`define ICSS_HF_LOCK_NS       3000
`define ICSS_HF_STABLE_NS     6000
`define ICSS_TRIM_SLEW_NS     1000
`define ICSS_CYC(ns)          (((ns) + `ICSS_CLK_PERIOD_NS - 1) / `ICSS_CLK_PERIOD_NS)
`define ICSS_LF_WARM_CYC      `ICSS_CYC(`ICSS_LF_WARM_NS)
`define ICSS_MF_WARM_CYC      `ICSS_CYC(`ICSS_MF_WARM_NS)
`define ICSS_HF_WARM_CYC      `ICSS_CYC(`ICSS_HF_WARM_NS)
`define ICSS_HF_LOCK_CYC      `ICSS_CYC(`ICSS_HF_LOCK_NS)
`define ICSS_HF_STABLE_CYC    `ICSS_CYC(`ICSS_HF_STABLE_NS)
`define ICSS_TRIM_SLEW_CYC    `ICSS_CYC(`ICSS_TRIM_SLEW_NS)

`endif

// *** hdl/icss_pkg.sv ***
// Types shared by the internal clock source select block
package icss_pkg;

    // ------------------------------------------------------------------
    // Control and status layouts
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       sw_multiplier_enable;
        logic [3:0] int_freq_select;
        logic [1:0] sys_clk_select;
    } icss_ctrl_type;

    typedef struct packed {
        logic high_freq_ready_flag;
        logic high_freq_locked_flag;
        logic high_freq_stable_flag;
        logic mid_freq_ready_flag;
        logic low_freq_ready_flag;
    } icss_status_type;

    // ------------------------------------------------------------------
    // Sources and oscillator states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_LF,
        SRC_MF,
        SRC_HF
    } icss_src_type;

    typedef enum logic [1:0] {
        OSC_OFF,
        OSC_WARM,
        OSC_RUN
    } icss_osc_state_type;

    typedef struct packed {
        icss_src_type src;
        logic [3:0]   shift;
    } icss_freq_type;

endpackage

// *** hdl/icss_nco.sv ***
// Phase accumulator that models one oscillator as a tick stream
`timescale 1ns/1ps
module icss_nco
    import icss_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input  wire logic             clock_in,
    input  wire logic             rst_b_in,
    input  wire logic             clk_en_in,
    input  wire logic             run_in,
    input  wire logic [WIDTH-1:0] step_in,
    output logic                  tick_out
);

    logic [WIDTH-1:0] acc_q;
    logic [WIDTH:0]   sum;

    assign sum = {1'b0, acc_q} + {1'b0, step_in};

    // ------------------------------------------------------------------
    // Accumulator; carry out is one oscillator period
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            acc_q    <= '0;
            tick_out <= 1'b0;
        end else if (clk_en_in) begin
            if (run_in) begin
                acc_q    <= sum[WIDTH-1:0];
                tick_out <= sum[WIDTH];
            end else begin
                acc_q    <= '0;
                tick_out <= 1'b0;
            end
        end
    end

endmodule

// *** dv/icss_top_monitor.sv ***
// Assertion checker for the internal clock source select ports
`timescale 1ns/1ps
module icss_top_monitor
    import icss_pkg::*;
(
    input wire logic            clock_in, rst_b_in, clk_en_in, ctrl_wr_in, trim_wr_in,
    input wire logic            cfg_multiplier_enable_in, cfg_clock_out_enable_in,
    input wire logic            powerup_timer_need_in, multiplier_on_out,
    input wire logic            osc_input_pin_gpio_out, osc_output_pin_gpio_out,
    input wire logic [2:0]      cfg_source_select_in, osc_enable_out,
    input wire logic [5:0]      trim_in, osc_trim_reg_out,
    input wire icss_ctrl_type   ctrl_in, osc_control_reg_out,
    input wire icss_status_type osc_status_reg_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    sequence ctrl_wr_s; clk_en_in && ctrl_wr_in; endsequence
    sequence hf_off_s; clk_en_in && !osc_enable_out[2]; endsequence
    chk_mult_either: assert property (
        multiplier_on_out == (cfg_multiplier_enable_in | osc_control_reg_out.sw_multiplier_enable))
        else $error("multiplier enable wrong");
    chk_ctrl_load: assert property (
        ctrl_wr_s |=> osc_control_reg_out == $past(ctrl_in)) else $error("control not loaded");
    chk_trim_load: assert property (
        clk_en_in && trim_wr_in |=> osc_trim_reg_out == $past(trim_in)) else $error("trim not loaded");
    chk_input_pin_gpio: assert property (
        osc_input_pin_gpio_out == (cfg_source_select_in == 3'h4)) else $error("input pin use wrong");
    chk_clkout_select: assert property (
        cfg_source_select_in inside {3'h3, 3'h4} |-> osc_output_pin_gpio_out == !cfg_clock_out_enable_in)
        else $error("output pin use wrong");
    chk_hf_ready_drop: assert property (
        hf_off_s |=> !osc_status_reg_out.high_freq_ready_flag) else $error("high ready stays");
    chk_mf_ready_drop: assert property (
        clk_en_in && !osc_enable_out[1] |=> !osc_status_reg_out.mid_freq_ready_flag)
        else $error("mid ready stays");
    chk_lock_order: assert property (
        osc_status_reg_out.high_freq_stable_flag |-> osc_status_reg_out.high_freq_locked_flag
        && osc_status_reg_out.high_freq_ready_flag) else $error("stable before locked");
    chk_low_need: assert property (
        powerup_timer_need_in |-> osc_enable_out[0]) else $error("low oscillator off");
endmodule
bind icss_top icss_top_monitor mon_u (.*);

// *** dv/icss_ext_clk_model.sv ***
// Far-side clock sources: external clock and Timer1 crystal tick streams
`timescale 1ns/1ps
module icss_ext_clk_model #(
    parameter int EXT_DIV = 7,
    parameter int T1_DIV  = 61
) (
    input  wire logic       clock_in,
    input  wire logic [1:0] run_in,
    output logic            ext_tick_out,
    output logic            t1_tick_out,
    output logic            t1_ready_out
);
    int ec = 0, tc = 0;
    initial {ext_tick_out, t1_tick_out, t1_ready_out} = 3'h0;
    // A stopped source gives no ticks at all, never a stale pulse
    always @(posedge clock_in) begin
        ec <= (ec == EXT_DIV - 1) ? 0 : ec + 1;
        tc <= (tc == T1_DIV - 1) ? 0 : tc + 1;
        ext_tick_out <= run_in[0] && ec == 0;
        t1_tick_out <= run_in[1] && tc == 0;
        t1_ready_out <= run_in[1];
    end
endmodule

// *** dv/icss_top_tb_top.sv ***
// Self-checking testbench for the internal clock source select block
`timescale 1ns/1ps
module icss_top_tb_top
    import icss_pkg::*;
;
    logic clock_in = 1'b0, rst_b_in = 1'b0, clk_en_in = 1'b1, ctrl_wr_in = 1'b0, trim_wr_in = 1'b0;
    logic cfg_multiplier_enable_in = 1'b0, cfg_clock_out_enable_in = 1'b0;
    logic powerup_timer_need_in = 1'b0, watchdog_need_in = 1'b0, failsafe_need_in = 1'b0;
    logic [2:0] cfg_source_select_in = 3'h4, osc_enable_out;
    logic [5:0] trim_in = 6'h00, osc_trim_reg_out;
    logic [1:0] run = 2'h0;
    icss_ctrl_type ctrl_in = 7'h00, osc_control_reg_out;
    icss_status_type osc_status_reg_out;
    logic ext_clk_tick_in, timer1_tick_in, timer1_ready_in, multiplier_on_out, sys_tick_out;
    logic low_freq_tick_out, osc_input_pin_gpio_out, osc_output_pin_gpio_out;
    logic osc_output_pin_out, osc_output_pin_oe_out;
    int mismatches = 0, n_tests = 0, cyc = 0;
    wire logic [6:0] flg = {sys_tick_out, low_freq_tick_out, osc_status_reg_out};
    always #5 clock_in = ~clock_in;
    icss_ext_clk_model model_u (.clock_in(clock_in), .run_in(run), .ext_tick_out(ext_clk_tick_in),
        .t1_tick_out(timer1_tick_in), .t1_ready_out(timer1_ready_in));
    icss_top dut_u (.*);
    task automatic chk(input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_ctrl(input logic [6:0] v);
        @(negedge clock_in);
        ctrl_in = v;
        ctrl_wr_in = 1'b1;
        @(negedge clock_in);
        ctrl_wr_in = 1'b0;
    endtask
    // Bounded wait on one flag, so a dead oscillator cannot hang the run
    task automatic wt(input int b, input int lim);
        for (int i = 0; i < lim && flg[b] !== 1'b1; i++) @(negedge clock_in);
        chk({7'h00, flg[b]}, 8'h01);
    endtask
    task results;
        if (mismatches == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results;
        end
    end
    initial begin
        repeat (10) @(negedge clock_in);
        rst_b_in = 1'b1;
        repeat (3) @(negedge clock_in);
        chk({1'b0, osc_control_reg_out}, 8'h1c);
        chk({2'h0, osc_trim_reg_out}, 8'h00);
        chk({7'h00, osc_input_pin_gpio_out}, 8'h01);
        chk({5'h00, osc_output_pin_out, osc_output_pin_oe_out, osc_output_pin_gpio_out}, 8'h01);
        cfg_clock_out_enable_in = 1'b1;
        @(negedge clock_in);
        chk({6'h00, osc_output_pin_oe_out, osc_output_pin_gpio_out}, 8'h02);
        cfg_source_select_in = 3'h3;
        @(negedge clock_in);
        chk({7'h00, osc_input_pin_gpio_out}, 8'h00);
        for (int k = 0; k < 4; k++) begin
            cfg_multiplier_enable_in = k[1];
            wr_ctrl({k[0], 4'h7, 2'h0});
            chk({7'h00, multiplier_on_out}, {7'h00, k[1] | k[0]});
        end
        cfg_multiplier_enable_in = 1'b0;
        wr_ctrl({1'b0, 4'h7, 2'h2});
        chk({5'h00, osc_enable_out}, 8'h02);
        wt(1, 150);
        wt(6, 400);
        wr_ctrl({1'b0, 4'hf, 2'h3});
        chk({7'h00, osc_enable_out[2]}, 8'h01);
        wt(4, 200);
        wt(3, 400);
        chk({7'h00, flg[2]}, 8'h00);
        wt(2, 400);
        cfg_source_select_in = 3'h4;
        wr_ctrl({1'b1, 4'hf, 2'h0});
        wt(6, 10);
        @(negedge clock_in);
        wt(6, 4);
        wr_ctrl({1'b0, 4'h0, 2'h2});
        chk({5'h00, osc_enable_out}, 8'h01);
        wt(0, 300);
        wt(5, 4000);
        cfg_source_select_in = 3'h7;
        wr_ctrl({1'b0, 4'h7, 2'h0});
        for (int k = 0; k < 3; k++) begin
            {failsafe_need_in, watchdog_need_in, powerup_timer_need_in} = 3'h1 << k;
            @(negedge clock_in);
            chk({7'h00, osc_enable_out[0]}, 8'h01);
        end
        {failsafe_need_in, watchdog_need_in, powerup_timer_need_in} = 3'h0;
        run = 2'h1;
        @(negedge clock_in);
        chk({5'h00, osc_enable_out}, 8'h00);
        wt(6, 50);
        run = 2'h2;
        wr_ctrl({1'b0, 4'h7, 2'h1});
        wt(6, 200);
        for (int k = 0; k < 2; k++) begin
            @(negedge clock_in);
            trim_in = k[0] ? 6'h20 : 6'h1f;
            trim_wr_in = 1'b1;
            @(negedge clock_in);
            trim_wr_in = 1'b0;
            chk({2'h0, osc_trim_reg_out}, {2'h0, trim_in});
        end
        results;
    end
endmodule
